// ---- core/sbd_drive_ctrl.sv ----
// sensorless drive control core: duty translation, open-loop start, lead angle
module sbd_drive_ctrl #(
  parameter int SS_TICK_CYCLES   = sbd_pkg::SS_TICK_CYCLES,
  parameter int STARTUP_UNIT_CYC = sbd_pkg::STARTUP_UNIT_CYC,
  parameter int PWM_SAMPLE_DIV   = sbd_pkg::PWM_SAMPLE_DIV
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       pwm_duty_in,
  input  wire logic       bemf_valid_in,
  input  wire logic       bemf_zero_cross_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic      [7:0] drive_duty_out,
  output logic      [7:0] current_limit_level_out,
  output logic      [4:0] lead_angle_out,
  output logic      [2:0] comm_step_out,
  output logic            closed_loop_out,
  output logic            input_fault_out,
  output logic            standby_out
);

  if (SS_TICK_CYCLES < 1 || SS_TICK_CYCLES > 16777215) begin : g_bad_ss
    $error("soft start tick out of range");
  end
  if (STARTUP_UNIT_CYC < 1 || STARTUP_UNIT_CYC > 65535) begin : g_bad_st
    $error("startup unit out of range");
  end

  // ----------------------------------------------------------------
  // input pwm measurement
  // ----------------------------------------------------------------
  sbd_pwm_if pwm_if ();

  sbd_pwm_meas #(
    .SAMPLE_DIV (PWM_SAMPLE_DIV)
  ) u_meas (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .pwm_duty_in (pwm_duty_in),
    .meas_if     (pwm_if)
  );

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic       run_q;
  logic [7:0] duty_lower_q;
  logic [7:0] duty_upper_q;
  logic [2:0] low_range_behaviour_select_q;
  logic [2:0] high_range_behaviour_select_q;
  logic [5:0] soft_start_time_q;
  logic [7:0] startup_commutation_period_q;
  logic [4:0] low_speed_lead_angle_q;
  logic [4:0] high_speed_lead_angle_q;
  logic [4:0] lead_angle_max_limit_q;
  logic [7:0] rdata_q;
  sbd_pkg::sbd_state_t state_q;
  sbd_pkg::sbd_state_t state_d;

  // settings written at any time; restricted ones are the host's duty to hold
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      run_q                         <= 1'b0;
      duty_lower_q                  <= sbd_pkg::RST_DUTY_LOWER;
      duty_upper_q                  <= sbd_pkg::RST_DUTY_UPPER;
      low_range_behaviour_select_q  <= sbd_pkg::RST_LOW_SEL;
      high_range_behaviour_select_q <= sbd_pkg::RST_HIGH_SEL;
      soft_start_time_q             <= sbd_pkg::RST_SOFT_START;
      startup_commutation_period_q  <= sbd_pkg::RST_STARTUP;
      low_speed_lead_angle_q        <= sbd_pkg::RST_LEAD_LOW;
      high_speed_lead_angle_q       <= sbd_pkg::RST_LEAD_HIGH;
      lead_angle_max_limit_q        <= sbd_pkg::RST_LEAD_LIMIT;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        sbd_pkg::REG_CONTROL:      run_q <= reg_wdata_in[sbd_pkg::CTRL_RUN_BIT];
        sbd_pkg::REG_DUTY_LOWER:   duty_lower_q <= reg_wdata_in;
        sbd_pkg::REG_DUTY_UPPER:   duty_upper_q <= reg_wdata_in;
        sbd_pkg::REG_RANGE_SELECT:
        begin
          low_range_behaviour_select_q  <= reg_wdata_in[sbd_pkg::RSEL_LOW_LSB +: 3];
          high_range_behaviour_select_q <= reg_wdata_in[sbd_pkg::RSEL_HIGH_LSB +: 3];
        end
        sbd_pkg::REG_SOFT_START:   soft_start_time_q <= reg_wdata_in[5:0];
        sbd_pkg::REG_STARTUP_PER:  startup_commutation_period_q <= reg_wdata_in;
        sbd_pkg::REG_LEAD_LOW:     low_speed_lead_angle_q <= reg_wdata_in[4:0];
        sbd_pkg::REG_LEAD_HIGH:    high_speed_lead_angle_q <= reg_wdata_in[4:0];
        sbd_pkg::REG_LEAD_LIMIT:   lead_angle_max_limit_q <= reg_wdata_in[4:0];
        default:                   run_q <= run_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // duty translation
  // ----------------------------------------------------------------
  wire  [7:0]  meas_duty  = pwm_if.duty_code;
  wire         in_fault   = pwm_if.fault;
  wire         below_low  = meas_duty < duty_lower_q;
  wire         above_high = meas_duty > duty_upper_q;
  wire  [7:0]  span       = duty_upper_q - duty_lower_q;
  wire  [15:0] lin_num    = {8'h00, meas_duty - duty_lower_q} * 16'h00ff;
  wire  [15:0] lin_quot   = (span == 8'h00) ? 16'h0000 : lin_num / {8'h00, span};
  wire  [7:0]  lin_duty   = (lin_quot > 16'h00ff) ? 8'hff : lin_quot[7:0];
  wire  [7:0]  low_duty   = sbd_pkg::sbd_behaviour_duty(low_range_behaviour_select_q);
  wire  [7:0]  high_duty  = sbd_pkg::sbd_behaviour_duty(high_range_behaviour_select_q);
  wire  [7:0]  map_duty   = (in_fault || below_low) ? low_duty :
                            above_high              ? high_duty : lin_duty;
  wire         running    = (state_q != sbd_pkg::SBD_STANDBY);
  wire  [7:0]  drive_d    = running ? map_duty : 8'h00;

  // ----------------------------------------------------------------
  // start sequence
  // ----------------------------------------------------------------
  logic [15:0] st_div_q;
  logic [7:0]  st_cnt_q;
  logic [2:0]  step_q;
  logic [23:0] ss_div_q;
  logic [5:0]  ss_cnt_q;
  logic [7:0]  level_q;
  logic [7:0]  drive_q;
  logic [4:0]  lead_q;
  wire         unit_tick  = (st_div_q == 16'(STARTUP_UNIT_CYC - 1));
  wire  [7:0]  per_code   = (startup_commutation_period_q == 8'h00) ? 8'h01 :
                            startup_commutation_period_q;
  wire         comm_open  = unit_tick && (st_cnt_q == per_code - 8'h01);
  wire         open_st    = (state_q == sbd_pkg::SBD_OPEN);
  wire         closed_st  = (state_q == sbd_pkg::SBD_CLOSED);
  wire         step_adv   = (open_st && comm_open) || (closed_st && bemf_zero_cross_in);
  wire  [2:0]  step_next  = (step_q == sbd_pkg::LAST_STEP) ? 3'h0 : step_q + 3'h1;
  wire         ss_tick    = (ss_div_q == 24'(SS_TICK_CYCLES - 1));
  wire         ramp_done  = (level_q == sbd_pkg::DUTY_FULL);
  wire         ss_step    = ss_tick && (ss_cnt_q + 6'h01 >= soft_start_time_q);

  // open loop first, closed loop on valid back-emf
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      sbd_pkg::SBD_STANDBY: if (run_q) state_d = sbd_pkg::SBD_OPEN;
      sbd_pkg::SBD_OPEN:    if (!run_q) state_d = sbd_pkg::SBD_STANDBY;
                            else if (bemf_valid_in) state_d = sbd_pkg::SBD_CLOSED;
      sbd_pkg::SBD_CLOSED:  if (!run_q) state_d = sbd_pkg::SBD_STANDBY;
                            else if (!bemf_valid_in) state_d = sbd_pkg::SBD_OPEN;
      default:              state_d = sbd_pkg::SBD_STANDBY;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q  <= sbd_pkg::SBD_STANDBY;
      st_div_q <= 16'h0000;
      st_cnt_q <= 8'h00;
      step_q   <= 3'h0;
    end
    else
    begin
      state_q  <= state_d;
      st_div_q <= (!open_st || unit_tick) ? 16'h0000 : st_div_q + 16'h0001;
      if (!open_st || comm_open)
        st_cnt_q <= 8'h00;
      else if (unit_tick)
        st_cnt_q <= st_cnt_q + 8'h01;
      if (!running)
        step_q <= 3'h0;
      else if (step_adv)
        step_q <= step_next;
    end
  end

  // current limit ramps from zero; a zero time code jumps straight to full
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ss_div_q <= 24'h00_0000;
      ss_cnt_q <= 6'h00;
      level_q  <= 8'h00;
    end
    else if (!running)
    begin
      ss_div_q <= 24'h00_0000;
      ss_cnt_q <= 6'h00;
      level_q  <= 8'h00;
    end
    else if (!ramp_done)
    begin
      ss_div_q <= ss_tick ? 24'h00_0000 : ss_div_q + 24'h00_0001;
      if (soft_start_time_q == 6'h00)
        level_q <= sbd_pkg::DUTY_FULL;
      else if (ss_step)
      begin
        ss_cnt_q <= 6'h00;
        level_q  <= level_q + 8'h01;
      end
      else if (ss_tick)
        ss_cnt_q <= ss_cnt_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // lead angle
  // ----------------------------------------------------------------
  // weighted blend by output duty
  wire  [12:0] lead_sum   = ({8'h00, low_speed_lead_angle_q} * {5'h00, 8'hff - drive_q}) +
                            ({8'h00, high_speed_lead_angle_q} * {5'h00, drive_q});
  wire  [12:0] lead_quot  = lead_sum / 13'h00ff;
  wire  [4:0]  lead_blend = lead_quot[4:0];
  wire  [4:0]  lead_d     = (lead_blend > lead_angle_max_limit_q) ?
                            lead_angle_max_limit_q : lead_blend;

  // output registers; lead follows the registered drive one cycle later
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      drive_q <= 8'h00;
      lead_q  <= 5'h00;
    end
    else
    begin
      drive_q <= drive_d;
      lead_q  <= lead_d;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  wire  [7:0]  status_word = {1'b0, step_q, 1'b0, ramp_done, closed_st, in_fault};
  logic [7:0]  read_mux;

  // unmapped offsets read zero; data holds only the cycle after the strobe
  always_comb
  begin
    case (reg_addr_in)
      sbd_pkg::REG_CONTROL:      read_mux = {7'h00, run_q};
      sbd_pkg::REG_DUTY_LOWER:   read_mux = duty_lower_q;
      sbd_pkg::REG_DUTY_UPPER:   read_mux = duty_upper_q;
      sbd_pkg::REG_RANGE_SELECT: read_mux = {1'b0, high_range_behaviour_select_q,
                                             1'b0, low_range_behaviour_select_q};
      sbd_pkg::REG_SOFT_START:   read_mux = {2'h0, soft_start_time_q};
      sbd_pkg::REG_STARTUP_PER:  read_mux = startup_commutation_period_q;
      sbd_pkg::REG_LEAD_LOW:     read_mux = {3'h0, low_speed_lead_angle_q};
      sbd_pkg::REG_LEAD_HIGH:    read_mux = {3'h0, high_speed_lead_angle_q};
      sbd_pkg::REG_LEAD_LIMIT:   read_mux = {3'h0, lead_angle_max_limit_q};
      sbd_pkg::REG_STATUS:       read_mux = status_word;
      sbd_pkg::REG_MEAS_DUTY:    read_mux = meas_duty;
      sbd_pkg::REG_DRIVE_DUTY:   read_mux = drive_q;
      sbd_pkg::REG_LEAD_ANGLE:   read_mux = {3'h0, lead_q};
      sbd_pkg::REG_CURR_LEVEL:   read_mux = level_q;
      default:                   read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_q <= 8'h00;
    else
      rdata_q <= reg_rd_in ? read_mux : 8'h00;
  end

  assign reg_rdata_out           = rdata_q;
  assign drive_duty_out          = drive_q;
  assign current_limit_level_out = level_q;
  assign lead_angle_out          = lead_q;
  assign comm_step_out           = step_q;
  assign closed_loop_out         = closed_st;
  assign input_fault_out         = in_fault;
  assign standby_out             = !running;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wire steady = running && !reg_wr_in;

  property p_low_range;
    @(posedge sys_clk_in) disable iff (rst_in)
    steady && !in_fault && below_low |=> drive_q == $past(low_duty);
  endproperty
  a_low_range: assert property (p_low_range) else $error("low range duty wrong");

  property p_mid_ends;
    @(posedge sys_clk_in) disable iff (rst_in)
    steady && !in_fault && (meas_duty == duty_upper_q) && (span != 8'h00)
      |=> drive_q == 8'hff;
  endproperty
  a_mid_ends: assert property (p_mid_ends) else $error("upper threshold not full");

  property p_high_off;
    @(posedge sys_clk_in) disable iff (rst_in)
    steady && !in_fault && above_high && (high_range_behaviour_select_q == sbd_pkg::BEH_OFF)
      |=> drive_q == 8'h00;
  endproperty
  a_high_off: assert property (p_high_off) else $error("high range off wrong");

  property p_high_full;
    @(posedge sys_clk_in) disable iff (rst_in)
    steady && !in_fault && above_high && (high_range_behaviour_select_q == sbd_pkg::BEH_FULL)
      |=> drive_q == 8'hff;
  endproperty
  a_high_full: assert property (p_high_full) else $error("code 4 not full duty");

  property p_closed_needs_bemf;
    @(posedge sys_clk_in) disable iff (rst_in)
    $rose(closed_st) |-> $past(open_st) && $past(bemf_valid_in);
  endproperty
  a_closed_needs_bemf: assert property (p_closed_needs_bemf) else $error("closed without bemf");

  property p_open_period;
    @(posedge sys_clk_in) disable iff (rst_in)
    open_st && $past(open_st) && $changed(step_q) |-> $past(comm_open);
  endproperty
  a_open_period: assert property (p_open_period) else $error("open step off period");

  property p_ramp_rise;
    @(posedge sys_clk_in) disable iff (rst_in)
    $rose(running) |-> level_q == 8'h00 ##1 (level_q <= 8'h01 || soft_start_time_q == 6'h00);
  endproperty
  a_ramp_rise: assert property (p_ramp_rise) else $error("ramp not from zero");

  property p_lead_low;
    @(posedge sys_clk_in) disable iff (rst_in)
    (drive_q == 8'h00) && (low_speed_lead_angle_q <= lead_angle_max_limit_q) && !reg_wr_in
      |=> lead_q == $past(low_speed_lead_angle_q);
  endproperty
  a_lead_low: assert property (p_lead_low) else $error("lead not low-speed at zero");

  property p_lead_clamp;
    @(posedge sys_clk_in) disable iff (rst_in)
    !$past(reg_wr_in) |-> lead_q <= $past(lead_angle_max_limit_q);
  endproperty
  a_lead_clamp: assert property (p_lead_clamp) else $error("lead above limit");

  property p_fault_low;
    @(posedge sys_clk_in) disable iff (rst_in)
    steady && in_fault |=> drive_q == $past(low_duty) && $past(input_fault_out);
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("fault drive wrong");

endmodule

// ---- core/sbd_pkg.sv ----
// shared constants, types and decode functions of the sensorless drive control
package sbd_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ           = 20000;
  localparam int SS_UNIT_MS        = 100;
  localparam int SS_LEVEL_STEPS    = 256;
  localparam int SS_TICK_CYCLES    = SS_UNIT_MS * CLK_KHZ / SS_LEVEL_STEPS;
  localparam int STARTUP_UNIT_US   = 100;
  localparam int STARTUP_UNIT_CYC  = (STARTUP_UNIT_US * CLK_KHZ + 999) / 1000;
  localparam int PWM_SAMPLE_DIV    = 16;
  localparam int PWM_WINDOW_SAMPLES = 255;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CONTROL      = 8'h00;
  localparam logic [7:0] REG_DUTY_LOWER   = 8'h01;
  localparam logic [7:0] REG_DUTY_UPPER   = 8'h02;
  localparam logic [7:0] REG_RANGE_SELECT = 8'h03;
  localparam logic [7:0] REG_SOFT_START   = 8'h04;
  localparam logic [7:0] REG_STARTUP_PER  = 8'h05;
  localparam logic [7:0] REG_LEAD_LOW     = 8'h06;
  localparam logic [7:0] REG_LEAD_HIGH    = 8'h07;
  localparam logic [7:0] REG_LEAD_LIMIT   = 8'h08;
  localparam logic [7:0] REG_STATUS       = 8'h09;
  localparam logic [7:0] REG_MEAS_DUTY    = 8'h0a;
  localparam logic [7:0] REG_DRIVE_DUTY   = 8'h0b;
  localparam logic [7:0] REG_LEAD_ANGLE   = 8'h0c;
  localparam logic [7:0] REG_CURR_LEVEL   = 8'h0d;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_BIT      = 0;
  localparam int RSEL_LOW_LSB      = 0;
  localparam int RSEL_HIGH_LSB     = 4;
  localparam int STAT_FAULT_BIT    = 0;
  localparam int STAT_CLOSED_BIT   = 1;
  localparam int STAT_RAMP_BIT     = 2;
  localparam int STAT_STEP_LSB     = 4;
  localparam logic [7:0] RST_DUTY_LOWER = 8'h00;
  localparam logic [7:0] RST_DUTY_UPPER = 8'hff;
  localparam logic [2:0] RST_LOW_SEL    = 3'h0;
  localparam logic [2:0] RST_HIGH_SEL   = 3'h4;
  localparam logic [5:0] RST_SOFT_START = 6'h22;
  localparam logic [7:0] RST_STARTUP    = 8'h32;
  localparam logic [4:0] RST_LEAD_LOW   = 5'h00;
  localparam logic [4:0] RST_LEAD_HIGH  = 5'h00;
  localparam logic [4:0] RST_LEAD_LIMIT = 5'h1f;
  localparam logic [7:0] DUTY_FULL      = 8'hff;
  localparam logic [2:0] LAST_STEP      = 3'h5;

  // ----------------------------------------------------------------
  // behaviour codes outside the mapped range
  // ----------------------------------------------------------------
  localparam logic [2:0] BEH_OFF  = 3'h0;
  localparam logic [2:0] BEH_25   = 3'h1;
  localparam logic [2:0] BEH_50   = 3'h2;
  localparam logic [2:0] BEH_75   = 3'h3;
  localparam logic [2:0] BEH_FULL = 3'h4;

  typedef enum logic [2:0] {
    SBD_STANDBY = 3'b001,
    SBD_OPEN    = 3'b010,
    SBD_CLOSED  = 3'b100
  } sbd_state_t;

  // drive duty chosen by a behaviour select code
  function automatic logic [7:0] sbd_behaviour_duty(input logic [2:0] sel);
    logic [7:0] duty;
    duty = 8'h00;
    case (sel)
      BEH_25:   duty = 8'h40;
      BEH_50:   duty = 8'h80;
      BEH_75:   duty = 8'hc0;
      BEH_FULL: duty = 8'hff;
      default:  duty = 8'h00;
    endcase
    return duty;
  endfunction

endpackage

// ---- core/sbd_pwm_if.sv ----
// measured input pwm duty carried from the measurement block to the control core
interface sbd_pwm_if;
  logic [7:0] duty_code;
  logic       fault;
  logic       update;
  modport meas (output duty_code, output fault, output update);
  modport user (input duty_code, input fault, input update);
endinterface

// ---- core/sbd_pwm_meas.sv ----
// input pwm duty measurement over a fixed sampling window
module sbd_pwm_meas #(
  parameter int SAMPLE_DIV = sbd_pkg::PWM_SAMPLE_DIV
) (
  input  wire logic    sys_clk_in,
  input  wire logic    rst_in,
  input  wire logic    pwm_duty_in,
  sbd_pwm_if.meas      meas_if
);

  logic [15:0] div_q;
  logic [7:0]  samp_cnt_q;
  logic [7:0]  high_cnt_q;
  logic        prev_q;
  logic        edge_seen_q;
  logic [7:0]  duty_q;
  logic        fault_q;
  logic        update_q;
  wire         samp_tick  = (div_q == 16'(SAMPLE_DIV - 1));
  wire         win_end    = samp_tick && (samp_cnt_q == 8'(sbd_pkg::PWM_WINDOW_SAMPLES - 1));
  wire  [7:0]  high_next  = high_cnt_q + {7'h00, pwm_duty_in};
  wire         edge_now   = samp_tick && (pwm_duty_in != prev_q);

  if (SAMPLE_DIV < 1 || SAMPLE_DIV > 65535) begin : g_bad_div
    $error("sample divider out of range");
  end

  // window counters; a flat input shows no edge, so it flags a fault
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_q       <= 16'h0000;
      samp_cnt_q  <= 8'h00;
      high_cnt_q  <= 8'h00;
      prev_q      <= 1'b0;
      edge_seen_q <= 1'b0;
      duty_q      <= 8'h00;
      fault_q     <= 1'b1;
      update_q    <= 1'b0;
    end
    else
    begin
      div_q    <= samp_tick ? 16'h0000 : div_q + 16'h0001;
      update_q <= win_end;
      if (samp_tick)
      begin
        prev_q <= pwm_duty_in;
      end
      if (win_end)
      begin
        samp_cnt_q  <= 8'h00;
        high_cnt_q  <= 8'h00;
        edge_seen_q <= 1'b0;
        duty_q      <= high_next;
        fault_q     <= !(edge_seen_q || edge_now);
      end
      else if (samp_tick)
      begin
        samp_cnt_q  <= samp_cnt_q + 8'h01;
        high_cnt_q  <= high_next;
        edge_seen_q <= edge_seen_q || edge_now;
      end
    end
  end

  assign meas_if.duty_code = duty_q;
  assign meas_if.fault     = fault_q;
  assign meas_if.update    = update_q;

endmodule

// ---- test/sbd_drive_ctrl_tb.sv ----
// self-checking bench of the drive control core
module sbd_drive_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, pwm = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        bv, zc, cl, flt, sb;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, duty, lvl;
  logic [4:0]  lead;
  logic [2:0]  step;
  logic [31:0] seed = 32'h0000_78ff;
  int          num_errors = 0, compares = 0, pcnt = 0, pduty = 0, n, m, e;
  int          dq[$] = '{1, 31, 32, 128, 224, 225, 254};
  logic [7:0]  rst_tab[8] = '{8'h00, 8'hff, 8'h40, 8'h22, 8'h32, 8'h00, 8'h00, 8'h1f};
  logic [7:0]  cfg[8] = '{8'h20, 8'he0, 8'h00, 8'h01, 8'h03, 8'h04, 8'h14, 8'h0a};

  // ----
  // clock, pwm source, design and motor
  // ----
  always #25 clk = ~clk;
  // period of 255 cycles, so one window counts exactly the duty
  always @(posedge clk)
  begin
    pcnt <= (pcnt + 1) % 255;
    pwm <= pcnt < pduty;
  end
  sbd_drive_ctrl #(.SS_TICK_CYCLES(2), .STARTUP_UNIT_CYC(2), .PWM_SAMPLE_DIV(1)) i_dut (
    .sys_clk_in(clk), .rst_in(rst), .pwm_duty_in(pwm), .bemf_valid_in(bv),
    .bemf_zero_cross_in(zc), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .drive_duty_out(duty),
    .current_limit_level_out(lvl), .lead_angle_out(lead), .comm_step_out(step),
    .closed_loop_out(cl), .input_fault_out(flt), .standby_out(sb));
  sbd_motor_model i_motor (.sys_clk_in(clk), .comm_step_in(step), .closed_loop_in(cl),
    .bemf_valid_out(bv), .bemf_zero_cross_out(zc));

  // ----
  // tasks and reference model
  // ----
  task automatic chk(input string s, input logic [7:0] x, input logic [7:0] y);
    compares++;
    if (y !== x)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("register", x, rdata);
  endtask
  task automatic wait_step(output int c);
    logic [2:0] s;
    s = step;
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end
    while (step === s && c < 100);
  endtask
  function automatic int beh(input int c);
    int t[5] = '{0, 64, 128, 192, 255};
    return c < 5 ? t[c] : 0;
  endfunction
  // xorshift step for the random input duties
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task automatic close_out;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rst_tab[i]) rd_chk(8'(i + 1), rst_tab[i]);
    rd_chk(8'h3f, 8'h00);
    foreach (cfg[i]) wr_reg(8'(i + 1), cfg[i]);
    wr_reg(8'h00, 8'h01);
    repeat (3) @(posedge clk);
    chk("standby", 8'h00, {7'h00, sb});
    wait_step(n);
    wait_step(n);
    chk("open step gap", 8'd6, 8'(n));
    chk("open loop", 8'h00, {7'h00, cl});
    chk("ramp midway", 8'h01, 8'(lvl > 0 && lvl < 255));
    repeat (600) @(posedge clk);
    chk("ramp end", 8'hff, lvl);
    rd_chk(8'h0d, 8'hff);
    chk("closed loop", 8'h01, {7'h00, cl});
    for (int c = 0; c < 5; c++)
    begin
      wr_reg(8'h03, 8'(c));
      repeat (3) @(posedge clk);
      chk("fault duty", 8'(beh(c)), duty);
      chk("fault flag", 8'h01, {7'h00, flt});
    end
    repeat (6)
    begin
      seed = xs(seed);
      dq.push_back(1 + int'(seed % 254));
    end
    foreach (dq[i])
    begin
      wr_reg(8'h03, {1'b0, 3'(i % 5), 1'b0, 3'((i + 2) % 5)});
      pduty <= dq[i];
      repeat (600) @(posedge clk);
      rd_chk(8'h0a, 8'(dq[i]));
      m = dq[i] < 32 ? beh((i + 2) % 5) : dq[i] > 224 ? beh(i % 5) : (dq[i] - 32) * 255 / 192;
      e = (4 * (255 - m) + 20 * m) / 255;
      chk("drive duty", 8'(m), duty);
      rd_chk(8'h0b, 8'(m));
      chk("fault", 8'h00, {7'h00, flt});
      chk("lead", 8'(e > 10 ? 10 : e), {3'h0, lead});
    end
    wr_reg(8'h00, 8'h00);
    repeat (3) @(posedge clk);
    chk("stop duty", 8'h00, duty);
    chk("stop step", 8'h00, {5'h00, step});
    // second reset after the stop: settings and flags back to their reset values
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'h03, 8'h40);
    chk("reset fault", 8'h01, {7'h00, flt});
    chk("reset standby", 8'h01, {7'h00, sb});
    close_out();
  end
  // watchdog well past the expected run length
  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule

// ---- test/sbd_motor_model.sv ----
// behavioural motor: back-emf appears after some forced steps
module sbd_motor_model (
  input  wire logic       sys_clk_in,
  input  wire logic [2:0] comm_step_in,
  input  wire logic       closed_loop_in,
  output logic            bemf_valid_out = 1'b0,
  output logic            bemf_zero_cross_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int         steps = 0;
  int         gap = 0;
  logic [2:0] last_q = 3'h0;
  // slow rotor speed
  // rotor locks after twelve steps, zero cross every 8 cycles
  always @(posedge sys_clk_in)
  begin
    last_q <= comm_step_in;
    steps <= steps + int'(comm_step_in != last_q);
    bemf_valid_out <= steps >= 12;
    gap <= closed_loop_in ? (gap + 1) % 8 : 0;
    bemf_zero_cross_out <= closed_loop_in && gap == 7;
  end
endmodule
